//--- rtl/cable_diag_pkg.sv
// constants for the cable diagnostics control and results block
package cable_diag_pkg;
    localparam logic [15:0] TERM_CFG_ADDR = 16'hb685;
    localparam logic [15:0] LAUNCH_ADDR = 16'hba1b;
    localparam logic [15:0] XPAIR_ADDR = 16'hba1c;
    localparam logic [15:0] PAIR0_ADDR = 16'hba1d;
    localparam logic [15:0] TERM_CFG_RST = 16'h0001;
    localparam logic [15:0] LAUNCH_RST = 16'h0000;
    localparam logic [15:0] XPAIR_RST = 16'h0000;
    localparam logic [15:0] PAIR0_RST = 16'h0000;
    localparam int BIT_CTRL = 0;
    localparam int BIT_BUSY = 10;
    localparam int BIT_XSIM = 7;
    localparam int BIT_SIM = 6;
    localparam int BIT_XSHORT = 3;
    localparam int BIT_SHORT = 2;
    localparam int BIT_OPEN = 1;
    localparam int BIT_GOOD = 0;
    // bits a cross-pair check may post
    localparam logic [15:0] XPAIR_FLAGS = 16'h0088;
    // bits that can ever be set in the results word
    localparam logic [15:0] PAIR0_VALID = 16'h04cf;
    localparam logic [15:0] ZERO16 = 16'h0000;
    typedef enum logic [1:0] {DIAG_IDLE, DIAG_RUN, DIAG_POST} diag_state_t;
endpackage

//--- rtl/diag_flag_reg.sv
// one result flag: cleared at launch, loaded at completion
`timescale 1ns/1ps
module diag_flag_reg (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic value_i,
    output logic flag_o
);
    logic flag_r;
    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_r;
        if (clear_i) begin
            flag_nxt = 1'b0;
        end else if (load_i) begin
            flag_nxt = value_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;
endmodule

//--- rtl/cable_diag_control_results.sv
// cable diagnostics control and pair 0 results registers
//
// Function
// - termination select resets to one
// - cleared select picks lowest common-mode impedance
// - writing start bit launches diagnostics run
// - start bit self clears on completion
// - results registers written at run end
// - cross-pair disable resets zero, skips checking
// - bit 10 flags unknown pair activity
// - bit 7 flags high-impedance cross short
// - bit 6 flags impedance mismatch
// - bit 3 flags cross-pair short
// - bit 2 flags short on pair
// - bit 1 flags open on pair
// - bit 0 flags good termination; reset zero
`timescale 1ns/1ps
module cable_diag_control_results (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic diag_run_o,
    output logic diag_xpair_check_o,
    output logic rx_low_cm_impedance_o,
    input wire logic diag_done_i,
    input wire logic [15:0] diag_result_i
);
    logic term_sel_r;
    logic term_sel_nxt;
    logic start_r;
    logic start_nxt;
    logic xpair_off_r;
    logic xpair_off_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic run_r;
    logic run_nxt;
    logic xchk_r;
    logic xchk_nxt;
    logic low_cm_r;
    logic low_cm_nxt;
    cable_diag_pkg::diag_state_t state_r;
    cable_diag_pkg::diag_state_t state_nxt;
    logic launch;
    logic load;
    logic [15:0] result_mask;
    logic [15:0] result_in;
    logic [15:0] pair0_q;

    assign launch = reg_wr_i && reg_addr_i == cable_diag_pkg::LAUNCH_ADDR
        && reg_wdata_i[cable_diag_pkg::BIT_CTRL]
        && state_r == cable_diag_pkg::DIAG_IDLE;
    assign load = state_r == cable_diag_pkg::DIAG_RUN && diag_done_i;
    // cross-pair flags stay clear when checking was disabled for the run
    assign result_mask = xpair_off_r
        ? (cable_diag_pkg::PAIR0_VALID & ~cable_diag_pkg::XPAIR_FLAGS)
        : cable_diag_pkg::PAIR0_VALID;
    assign result_in = diag_result_i & result_mask;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (cable_diag_pkg::PAIR0_VALID[gi]) begin : g_used
                diag_flag_reg u_flag (
                    .core_clk_i(core_clk_i),
                    .rst_b_i(rst_b_i),
                    .clear_i(launch),
                    .load_i(load),
                    .value_i(result_in[gi]),
                    .flag_o(pair0_q[gi])
                );
            end else begin : g_rsvd
                assign pair0_q[gi] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        state_nxt = state_r;
        start_nxt = start_r;
        case (state_r)
            cable_diag_pkg::DIAG_IDLE: begin
                if (launch) begin
                    state_nxt = cable_diag_pkg::DIAG_RUN;
                    start_nxt = 1'b1;
                end
            end
            cable_diag_pkg::DIAG_RUN: begin
                if (diag_done_i) begin
                    state_nxt = cable_diag_pkg::DIAG_POST;
                end
            end
            cable_diag_pkg::DIAG_POST: begin
                state_nxt = cable_diag_pkg::DIAG_IDLE;
                start_nxt = 1'b0;
            end
            default: begin
                state_nxt = cable_diag_pkg::DIAG_IDLE;
                start_nxt = 1'b0;
            end
        endcase
    end

    always_comb begin
        term_sel_nxt = term_sel_r;
        xpair_off_nxt = xpair_off_r;
        if (reg_wr_i && reg_addr_i == cable_diag_pkg::TERM_CFG_ADDR) begin
            term_sel_nxt = reg_wdata_i[cable_diag_pkg::BIT_CTRL];
        end else if (reg_wr_i && reg_addr_i == cable_diag_pkg::XPAIR_ADDR
            && state_r == cable_diag_pkg::DIAG_IDLE) begin
            // held steady during a run so flags match the setting used
            xpair_off_nxt = reg_wdata_i[cable_diag_pkg::BIT_CTRL];
        end
    end

    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            if (reg_addr_i == cable_diag_pkg::TERM_CFG_ADDR) begin
                rdata_nxt = {15'h0000, term_sel_r};
            end else if (reg_addr_i == cable_diag_pkg::LAUNCH_ADDR) begin
                rdata_nxt = {15'h0000, start_r};
            end else if (reg_addr_i == cable_diag_pkg::XPAIR_ADDR) begin
                rdata_nxt = {15'h0000, xpair_off_r};
            end else if (reg_addr_i == cable_diag_pkg::PAIR0_ADDR) begin
                rdata_nxt = pair0_q;
            end else begin
                rdata_nxt = cable_diag_pkg::ZERO16;
            end
        end
    end

    always_comb begin
        run_nxt = state_nxt == cable_diag_pkg::DIAG_RUN;
        // checking enabled while disable bit is zero
        xchk_nxt = !xpair_off_nxt;
        low_cm_nxt = !term_sel_nxt;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_r <= cable_diag_pkg::DIAG_IDLE;
            term_sel_r <= cable_diag_pkg::TERM_CFG_RST[0];
            start_r <= cable_diag_pkg::LAUNCH_RST[0];
            xpair_off_r <= cable_diag_pkg::XPAIR_RST[0];
            rdata_r <= cable_diag_pkg::ZERO16;
            run_r <= 1'b0;
            xchk_r <= 1'b1;
            low_cm_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            term_sel_r <= term_sel_nxt;
            start_r <= start_nxt;
            xpair_off_r <= xpair_off_nxt;
            rdata_r <= rdata_nxt;
            run_r <= run_nxt;
            xchk_r <= xchk_nxt;
            low_cm_r <= low_cm_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign diag_run_o = run_r;
    assign diag_xpair_check_o = xchk_r;
    assign rx_low_cm_impedance_o = low_cm_r;

    a_start_self_clear: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (state_r == cable_diag_pkg::DIAG_RUN && diag_done_i)
        |=> ##1 !start_r)
        else $error("start bit did not self clear");
    a_launch_sets_start: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        launch |=> start_r && run_r)
        else $error("launch did not start run");
    a_results_loaded: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        load |=> pair0_q == $past(result_in))
        else $error("results not captured");
    a_launch_clears_flags: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        launch |=> pair0_q == cable_diag_pkg::ZERO16)
        else $error("old flags not cleared");
    a_flags_held: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (!launch && !load) |=> $stable(pair0_q))
        else $error("flags changed outside run");
    a_xpair_masked: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (load && xpair_off_r) |=> (pair0_q & cable_diag_pkg::XPAIR_FLAGS)
        == cable_diag_pkg::ZERO16)
        else $error("cross pair flag posted while disabled");
    a_low_cm_follows: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == cable_diag_pkg::TERM_CFG_ADDR)
        |=> rx_low_cm_impedance_o == !$past(reg_wdata_i[0]))
        else $error("termination output wrong");
    a_reserved_zero: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        (pair0_q & ~cable_diag_pkg::PAIR0_VALID) == cable_diag_pkg::ZERO16)
        else $error("reserved result bit set");
    a_busy_flag: assert property (
        @(posedge core_clk_i) disable iff (!rst_b_i)
        load |=> pair0_q[10] == $past(diag_result_i[10]))
        else $error("busy flag wrong");
endmodule

//--- test/cable_pair_model.sv
// behavioural analog engine and cable pair under diagnosis
`timescale 1ns/1ps
module cable_pair_model (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic [7:0] lat_i,
    input wire logic [15:0] flags_i,
    output logic done_o,
    output logic [15:0] result_o
);
    logic run_q;
    logic busy_r;
    logic [7:0] cnt_r;
    logic [15:0] noise_r;
    // flags are only meaningful with the done pulse; noise elsewhere
    assign result_o = done_o ? flags_i : noise_r;
    always @(posedge core_clk_i) begin
        done_o <= 1'b0;
        run_q <= run_i;
        noise_r <= {noise_r[14:0], ~(noise_r[15] ^ noise_r[10])};
        if (!rst_b_i) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
            noise_r <= 16'ha5c3;
        end else if (run_i && !run_q) begin
            busy_r <= 1'b1;
            cnt_r <= lat_i;
        end else if (busy_r && cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (busy_r) begin
            busy_r <= 1'b0;
            done_o <= 1'b1;
        end
    end
endmodule

//--- test/tb_top.sv
// self-checking bench for the cable diagnostics registers
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic diag_run_o;
    logic diag_xpair_check_o;
    logic rx_low_cm_impedance_o;
    logic diag_done_i;
    logic [15:0] diag_result_i;
    logic [7:0] lat = 8'h02;
    logic [15:0] flags = 16'h0000;
    logic [15:0] rd;
    integer seed = 32'h8100_a215;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 core_clk_i = ~core_clk_i;
    cable_diag_control_results i_dut (.core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .diag_run_o(diag_run_o),
        .diag_xpair_check_o(diag_xpair_check_o),
        .rx_low_cm_impedance_o(rx_low_cm_impedance_o),
        .diag_done_i(diag_done_i), .diag_result_i(diag_result_i));
    cable_pair_model i_cable (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .run_i(diag_run_o), .lat_i(lat), .flags_i(flags),
        .done_o(diag_done_i), .result_o(diag_result_i));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, far above the well under one thousand cycles the tests need
    always @(posedge core_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp,
                           input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
        @(negedge core_clk_i);
    endtask
    task automatic rd16(input logic [15:0] a);
        @(negedge core_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        @(negedge core_clk_i);
        rd = reg_rdata_o;
    endtask
    function automatic logic [15:0] exp_res(input logic [15:0] f,
                                            input logic dis);
        exp_res = f & cable_diag_pkg::PAIR0_VALID;
        if (dis) exp_res = exp_res & ~cable_diag_pkg::XPAIR_FLAGS;
    endfunction
    initial begin
        int i;
        int w;
        logic dis;
        logic [15:0] exp_w;
        repeat (20) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        rd16(cable_diag_pkg::TERM_CFG_ADDR);
        cmp16(rd, 16'h0001, "term reset");
        rd16(cable_diag_pkg::LAUNCH_ADDR);
        cmp16(rd, 16'h0000, "start reset");
        rd16(cable_diag_pkg::XPAIR_ADDR);
        cmp16(rd, 16'h0000, "xpair reset");
        rd16(cable_diag_pkg::PAIR0_ADDR);
        cmp16(rd, 16'h0000, "results reset");
        rd16(16'hba20);
        cmp16(rd, 16'h0000, "unmapped");
        cmp_bit(diag_xpair_check_o, 1'b1, "xpair check");
        cmp_bit(rx_low_cm_impedance_o, 1'b0, "term out");
        wr(cable_diag_pkg::TERM_CFG_ADDR, 16'h0000);
        cmp_bit(rx_low_cm_impedance_o, 1'b1, "low cm");
        wr(cable_diag_pkg::TERM_CFG_ADDR, 16'hffff);
        cmp_bit(rx_low_cm_impedance_o, 1'b0, "normal term");
        rd16(cable_diag_pkg::TERM_CFG_ADDR);
        cmp16(rd, 16'h0001, "term back");
        wr(cable_diag_pkg::PAIR0_ADDR, 16'hffff);
        rd16(cable_diag_pkg::PAIR0_ADDR);
        cmp16(rd, 16'h0000, "results ro");
        // only bit 0 launches; an even value must leave the engine idle
        wr(cable_diag_pkg::LAUNCH_ADDR, 16'hfffe);
        cmp_bit(diag_run_o, 1'b0, "even no launch");
        $display("test registers done");
        for (i = 0; i < 12; i++) begin
            dis = (i < 2) ? (i == 0) : 1'($random(seed));
            flags = (i < 2) ? 16'hffff : 16'($random(seed));
            lat = 8'(8 + {$random(seed)} % 20);
            wr(cable_diag_pkg::XPAIR_ADDR, {15'h0000, dis});
            cmp_bit(diag_xpair_check_o, ~dis, "xpair out");
            // standby with link permit cleared is taken as given
            wr(cable_diag_pkg::LAUNCH_ADDR, 16'h0001);
            cmp_bit(diag_run_o, 1'b1, "run launched");
            // setting is locked while the engine runs
            wr(cable_diag_pkg::XPAIR_ADDR, {15'h0000, ~dis});
            cmp_bit(diag_xpair_check_o, ~dis, "xpair locked");
            rd16(cable_diag_pkg::PAIR0_ADDR);
            cmp16(rd, 16'h0000, "old flags cleared");
            w = 0;
            do begin
                rd16(cable_diag_pkg::LAUNCH_ADDR);
                w++;
            end while (rd[0] !== 1'b0 && w < 40);
            cmp16(rd, 16'h0000, "start self clear");
            cmp_bit(diag_run_o, 1'b0, "run ended");
            exp_w = exp_res(flags, dis);
            rd16(cable_diag_pkg::PAIR0_ADDR);
            cmp16(rd, exp_w, "results");
            // a new cross-pair setting must not touch posted flags
            wr(cable_diag_pkg::XPAIR_ADDR, {15'h0000, ~dis});
            rd16(cable_diag_pkg::PAIR0_ADDR);
            cmp16(rd, exp_w, "results held");
        end
        $display("test runs done");
        // reset while the engine is busy must abandon the run
        lat = 8'h10;
        flags = 16'($random(seed));
        wr(cable_diag_pkg::LAUNCH_ADDR, 16'h0001);
        cmp_bit(diag_run_o, 1'b1, "run before reset");
        rst_b_i = 1'b0;
        repeat (20) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        cmp_bit(diag_run_o, 1'b0, "run after reset");
        cmp_bit(diag_xpair_check_o, 1'b1, "xpair after reset");
        cmp_bit(rx_low_cm_impedance_o, 1'b0, "term after reset");
        rd16(cable_diag_pkg::LAUNCH_ADDR);
        cmp16(rd, 16'h0000, "start after reset");
        rd16(cable_diag_pkg::PAIR0_ADDR);
        cmp16(rd, 16'h0000, "results after reset");
        wr(cable_diag_pkg::LAUNCH_ADDR, 16'h0001);
        w = 0;
        do begin
            rd16(cable_diag_pkg::LAUNCH_ADDR);
            w++;
        end while (rd[0] !== 1'b0 && w < 40);
        cmp16(rd, 16'h0000, "rerun self clear");
        rd16(cable_diag_pkg::PAIR0_ADDR);
        cmp16(rd, exp_res(flags, 1'b0), "rerun results");
        $display("test reset done");
        final_report();
    end
endmodule
